// ---- common/srcc_consts.vh ----
// Constants for the subsystem reset and clock control block.
`ifndef SRCC_CONSTS_VH
`define SRCC_CONSTS_VH
`define SRCC_RSN_POR 0
`define SRCC_RSN_FULL 1
`define SRCC_RSN_CORE 2
`define SRCC_RSN_DEBUG 3
`define SRCC_RSN_FABRIC 4
`define SRCC_RSN_WDOG 5
`define SRCC_RSN_GPIO 6
`define SRCC_RSN_CBUS 7
`define SRCC_RSN_SOFTCORE 8
`define SRCC_RSN_WIDTH 9
`define SRCC_NUM_FIC 5
`define SRCC_NUM_PERIPH 16
`define SRCC_NUM_GPIO 3
`define SRCC_DLL_THRESH_MHZ 125
`define SRCC_CLK_RC 2'h0
`define SRCC_CLK_PLL 2'h1
`define SRCC_DIV_CORE 3'h1
`define SRCC_DIV_L2AXI 3'h2
`define SRCC_DIV_AHB 3'h4
`define SRCC_MCLK_MHZ 20
`define SRCC_RST_HOLD_NS 200
`define SRCC_RST_HOLD_CYC ((`SRCC_RST_HOLD_NS * `SRCC_MCLK_MHZ + 999) / 1000)
`endif

// ---- verilog/srcc_top.v ----
// Reset cause recording, reset distribution and clock source control.
//
// Operation
// - Power-on reset fully resets cores, peripherals and fabric, not GPIO blocks; optional soft bits also reset controller bus regs.
// - Full subsystem reset clears cores, peripherals and fabric, not controller bus regs.
// - Core-only reset clears just the processor core complex.
// - Debugger reset is logged at bit 3 and acts as a full reset.
// - Fabric reset low at power-up holds subsystem in reset; logged at bit 4.
// - Later fabric reset assertion gives a full subsystem reset.
// - First watchdog reset is logged at bit 5.
// - Fabric GPIO reset logged at bit 6; resets only follower GPIO blocks.
// - Controller bus reset is logged at bit 7.
// - Software core reset through soft register is logged at bit 8.
// - Peripherals stay in reset after subsystem reset until software releases each.
// - Main PLL gives up to 625 MHz core clock (667 fast grade) plus 80 MHz.
// - PLL divided by 1 for cores, 2 for cache/AXI, 4 for AHB/APB.
// - After power-up and every subsystem reset the RC oscillator is selected.
// - Firmware may switch the source from RC oscillator to PLL at run time.
// - No automatic source change at power-up; main PLL keeps running.
// - Fabric interface clocks above 125 MHz go through their DLL.
// - Below 125 MHz the DLL is bypassed and edge-opposite retiming is used.
`timescale 1ns/1ps
`include "srcc_consts.vh"
module srcc_top #(
  parameter NUM_PERIPH = `SRCC_NUM_PERIPH,
  parameter NUM_GPIO = `SRCC_NUM_GPIO,
  parameter NUM_FIC = `SRCC_NUM_FIC,
  parameter HOLD_CYC = `SRCC_RST_HOLD_CYC
)(
  input wire mclk,
  input wire rst_b,
  input wire power_on_full_reset,
  input wire cbus_regs_soft_reset,
  input wire subsystem_full_reset,
  input wire core_complex_reset,
  input wire debugger_reset_cause,
  input wire fabric_subsystem_reset_n,
  input wire watchdog_reset_cause,
  input wire fabric_gpio_reset,
  input wire [NUM_GPIO-1:0] gpio_follow_fabric,
  input wire controller_bus_reset_cause,
  input wire soft_core_reset,
  input wire [`SRCC_RSN_WIDTH-1:0] reason_clear,
  input wire [NUM_PERIPH-1:0] periph_release,
  input wire clk_sel_pll_req,
  input wire fast_grade,
  input wire [NUM_FIC*10-1:0] fic_clk_mhz,
  output reg [`SRCC_RSN_WIDTH-1:0] reason_reg,
  output reg cbus_regs_reset_reg,
  output reg subsystem_reset_reg,
  output reg core_reset_reg,
  output reg fabric_axi_reset_reg,
  output reg [NUM_PERIPH-1:0] periph_reset_reg,
  output reg [NUM_GPIO-1:0] gpio_reset_reg,
  output reg clk_src_pll_reg,
  output reg pll_enable_reg,
  output reg [2:0] div_core_reg,
  output reg [2:0] div_l2axi_reg,
  output reg [2:0] div_ahb_reg,
  output reg [9:0] core_max_mhz_reg,
  output reg [NUM_FIC-1:0] fic_dll_en_reg,
  output reg [NUM_FIC-1:0] fic_negedge_retime_reg
);
  // Synchronised copies of all asynchronous request pins.
  localparam NSYNC = 10;
  wire [NSYNC-1:0] async_in;
  reg [NSYNC-1:0] sync1_reg;
  reg [NSYNC-1:0] sync2_reg;
  assign async_in[0] = power_on_full_reset;
  assign async_in[1] = cbus_regs_soft_reset;
  assign async_in[2] = subsystem_full_reset;
  assign async_in[3] = core_complex_reset;
  assign async_in[4] = debugger_reset_cause;
  // The fabric line is active low, so it is inverted before the synchroniser.
  assign async_in[5] = ~fabric_subsystem_reset_n;
  assign async_in[6] = watchdog_reset_cause;
  assign async_in[7] = fabric_gpio_reset;
  assign async_in[8] = controller_bus_reset_cause;
  assign async_in[9] = soft_core_reset;

  // First stage may go metastable; only the second stage reads it.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      sync1_reg <= {NSYNC{1'b0}};
    else
      sync1_reg <= async_in;
  end

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      sync2_reg <= {NSYNC{1'b0}};
    else
      sync2_reg <= sync1_reg;
  end

  wire por_s;
  wire cbus_soft_s;
  wire full_s;
  wire core_s;
  wire dbg_s;
  wire fab_s;
  wire wdog_s;
  wire gpio_s;
  wire cbus_s;
  wire softcore_s;
  assign por_s = sync2_reg[0];
  assign cbus_soft_s = sync2_reg[1];
  assign full_s = sync2_reg[2];
  assign core_s = sync2_reg[3];
  assign dbg_s = sync2_reg[4];
  assign fab_s = sync2_reg[5];
  assign wdog_s = sync2_reg[6];
  assign gpio_s = sync2_reg[7];
  assign cbus_s = sync2_reg[8];
  assign softcore_s = sync2_reg[9];

  // Rising edges so that a held request logs its cause once.
  reg [NSYNC-1:0] prev_reg;
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      prev_reg <= {NSYNC{1'b0}};
    else
      prev_reg <= sync2_reg;
  end
  wire [NSYNC-1:0] rise = sync2_reg & ~prev_reg;

  // Power-up window: a fabric reset seen before the first release counts as a hold.
  reg powered_reg;
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      powered_reg <= 1'b0;
    else if (!fab_s && !por_s)
      powered_reg <= 1'b1;
  end

  // Full-effect sources: controller request, debugger, fabric and power-on.
  wire full_any = full_s | dbg_s | fab_s | por_s;
  wire core_any = core_s | softcore_s | full_any;

  // Stretch a full reset for a minimum pulse width.
  localparam [15:0] HOLD_CYC_W = HOLD_CYC;
  reg [15:0] hold_cnt_reg;
  wire start_full = full_any;
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      hold_cnt_reg <= 16'h0000;
    else if (start_full)
      hold_cnt_reg <= HOLD_CYC_W;
    else if (hold_cnt_reg != 16'h0000)
      hold_cnt_reg <= hold_cnt_reg - 16'h0001;
  end
  wire full_active = start_full | (hold_cnt_reg != 16'h0000);

  reg [`SRCC_RSN_WIDTH-1:0] reason_set;
  always @*
  begin
    reason_set = {`SRCC_RSN_WIDTH{1'b0}};
    reason_set[`SRCC_RSN_POR] = rise[0];
    reason_set[`SRCC_RSN_FULL] = rise[2];
    reason_set[`SRCC_RSN_CORE] = rise[3];
    reason_set[`SRCC_RSN_DEBUG] = rise[4];
    reason_set[`SRCC_RSN_FABRIC] = rise[5] | (fab_s & ~powered_reg);
    reason_set[`SRCC_RSN_WDOG] = rise[6];
    reason_set[`SRCC_RSN_GPIO] = rise[7];
    reason_set[`SRCC_RSN_CBUS] = rise[8];
    reason_set[`SRCC_RSN_SOFTCORE] = rise[9];
  end

  // Reason bits are sticky across every subsystem reset; set wins over clear.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      reason_reg <= {`SRCC_RSN_WIDTH{1'b0}};
    else
      reason_reg <= reason_set | (reason_reg & ~reason_clear);
  end

  // Controller bus registers are only cleared by a power-on reset with the soft bit set.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      cbus_regs_reset_reg <= 1'b1;
    else
      cbus_regs_reset_reg <= por_s & cbus_soft_s;
  end

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      subsystem_reset_reg <= 1'b1;
    else
      subsystem_reset_reg <= full_active;
  end

  // The fabric bus is cleared with the subsystem so no transaction is left hanging.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      fabric_axi_reset_reg <= 1'b1;
    else
      fabric_axi_reset_reg <= full_active;
  end

  // A core-only request is not stretched; it lasts as long as it is held.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      core_reset_reg <= 1'b1;
    else
      core_reset_reg <= core_any | full_active;
  end

  // Only the GPIO blocks that follow the fabric line see its reset.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      gpio_reset_reg <= {NUM_GPIO{1'b1}};
    else
      gpio_reset_reg <= {NUM_GPIO{gpio_s}} & gpio_follow_fabric;
  end

  // Peripherals are held after a subsystem reset until released one by one.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      periph_reset_reg <= {NUM_PERIPH{1'b1}};
    else if (full_active)
      periph_reset_reg <= {NUM_PERIPH{1'b1}};
    else
      periph_reset_reg <= periph_reset_reg & ~periph_release;
  end

  // The PLL keeps running and the divider ratios never change.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pll_enable_reg <= 1'b1;
      div_core_reg <= `SRCC_DIV_CORE;
      div_l2axi_reg <= `SRCC_DIV_L2AXI;
      div_ahb_reg <= `SRCC_DIV_AHB;
    end
    else
    begin
      pll_enable_reg <= 1'b1;
      div_core_reg <= `SRCC_DIV_CORE;
      div_l2axi_reg <= `SRCC_DIV_L2AXI;
      div_ahb_reg <= `SRCC_DIV_AHB;
    end
  end

  // The core ceiling follows the speed grade of the part.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      core_max_mhz_reg <= 10'h271;
    else
      core_max_mhz_reg <= fast_grade ? 10'h29B : 10'h271;
  end

  // Clock source: RC oscillator after every subsystem reset, PLL only on firmware request.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      clk_src_pll_reg <= 1'b0;
    else if (full_active)
      clk_src_pll_reg <= 1'b0;
    else if (clk_sel_pll_req)
      clk_src_pll_reg <= 1'b1;
  end

  // Per-interface DLL or edge-opposite retiming choice.
  localparam [9:0] DLL_THRESH = `SRCC_DLL_THRESH_MHZ;
  wire [NUM_FIC-1:0] fic_fast;
  wire [NUM_FIC-1:0] fic_slow;
  genvar g;
  generate
    for (g = 0; g < NUM_FIC; g = g + 1)
    begin : fic_mode
      wire [9:0] f;
      assign f = fic_clk_mhz[g*10 +: 10];
      assign fic_fast[g] = (f > DLL_THRESH);
      assign fic_slow[g] = (f < DLL_THRESH);
    end
  endgenerate

  // Exactly at the threshold neither path is chosen; the interface must not run there.
  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fic_dll_en_reg <= {NUM_FIC{1'b0}};
      fic_negedge_retime_reg <= {NUM_FIC{1'b1}};
    end
    else
    begin
      fic_dll_en_reg <= fic_fast;
      fic_negedge_retime_reg <= fic_slow;
    end
  end
endmodule

// ---- verification/srcc_top_asserts.sv ----
// Concurrent checks on the reset and clock control ports.
`timescale 1ns/1ps
module srcc_asserts (
  input mclk, rst_b, subsystem_full_reset, core_complex_reset, debugger_reset_cause,
  input watchdog_reset_cause, soft_core_reset, subsystem_reset_reg, core_reset_reg,
  input clk_src_pll_reg, pll_enable_reg,
  input [8:0] reason_clear, reason_reg,
  input [2:0] div_core_reg, div_l2axi_reg, div_ahb_reg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_full_logged: assert property ($rose(subsystem_full_reset) |-> ##3 reason_reg[1]
    && subsystem_reset_reg) else $error("full reset not logged");
  a_core_logged: assert property ($rose(core_complex_reset) |-> ##3 reason_reg[2]
    && core_reset_reg) else $error("core reset not logged");
  a_debug_full: assert property ($rose(debugger_reset_cause) |-> ##3 reason_reg[3]
    && subsystem_reset_reg) else $error("debugger reset not applied");
  a_wdog_logged: assert property ($rose(watchdog_reset_cause) |-> ##3 reason_reg[5])
    else $error("watchdog cause missing");
  a_soft_logged: assert property ($rose(soft_core_reset) |-> ##3 reason_reg[8])
    else $error("soft core cause missing");
  a_reason_sticky: assert property (&(reason_reg | ~$past(reason_reg) | $past(reason_clear)))
    else $error("reason bit lost");
  a_rc_on_reset: assert property ($rose(subsystem_reset_reg) |-> !clk_src_pll_reg)
    else $error("clock not on RC");
  a_div_fixed: assert property (pll_enable_reg && div_core_reg == 3'h1
    && div_l2axi_reg == 3'h2 && div_ahb_reg == 3'h4) else $error("divider or PLL wrong");
endmodule
bind srcc_top srcc_asserts chk_u (.*);

// ---- verification/srcc_far_end.sv ----
// Far-side model: fabric reset line and paired controller resets.
`timescale 1ns/1ps
module srcc_far_end (
  input mclk, go, kind,
  output fab_n, full, core
);
  reg [2:0] cnt_reg = 3'h0;
  reg kind_reg = 1'b0;
  assign fab_n = !(cnt_reg != 3'h0 && !kind_reg);
  // The full reset always travels with the core reset to flush bus traffic.
  assign full = cnt_reg != 3'h0 && kind_reg;
  assign core = full;
  always @(negedge mclk)
    if (cnt_reg != 3'h0)
      cnt_reg <= cnt_reg - 3'h1;
    else if (go)
    begin
      cnt_reg <= 3'h6;
      kind_reg <= kind;
    end
endmodule

// ---- verification/srcc_top_bench.sv ----
// Self-checking bench for the reset and clock control block.
`timescale 1ns/1ps
module srcc_top_bench;
  reg mclk = 0, rst_b = 0, cbs = 0, go = 0, kind = 0, sel = 0, fg = 0;
  reg [8:0] req = 9'h001, clr = 0;
  reg [3:0] rel = 0;
  reg [2:0] gf = 0;
  reg [49:0] fabric_interface_port = 0;
  wire fab_n, p_full, p_core, cbr, sub, core, pll, axi;
  wire [8:0] rsn;
  wire [3:0] per;
  wire [2:0] gpr;
  wire [9:0] cmax;
  wire [4:0] dll, ret;
  integer bad_count = 0, compares = 0, k, i, j, f;
  always #25 mclk = ~mclk;
  srcc_far_end far_u (.mclk(mclk), .go(go), .kind(kind), .fab_n(fab_n), .full(p_full),
    .core(p_core));
  srcc_top #(.NUM_PERIPH(4), .HOLD_CYC(1)) dut_u (.mclk(mclk), .rst_b(rst_b),
    .power_on_full_reset(req[0]), .cbus_regs_soft_reset(cbs),
    .subsystem_full_reset(req[1] | p_full), .core_complex_reset(req[2] | p_core),
    .debugger_reset_cause(req[3]), .fabric_subsystem_reset_n(fab_n),
    .watchdog_reset_cause(req[5]), .fabric_gpio_reset(req[6]), .gpio_follow_fabric(gf),
    .controller_bus_reset_cause(req[7]), .soft_core_reset(req[8]), .reason_clear(clr),
    .periph_release(rel), .clk_sel_pll_req(sel), .fast_grade(fg), .fic_clk_mhz(fabric_interface_port),
    .reason_reg(rsn), .cbus_regs_reset_reg(cbr), .subsystem_reset_reg(sub),
    .core_reset_reg(core), .fabric_axi_reset_reg(axi), .periph_reset_reg(per),
    .gpio_reset_reg(gpr), .clk_src_pll_reg(pll), .pll_enable_reg(), .div_core_reg(),
    .div_l2axi_reg(), .div_ahb_reg(), .core_max_mhz_reg(cmax), .fic_dll_en_reg(dll),
    .fic_negedge_retime_reg(ret));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  task close_out;
    begin
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // Causes that act as a full subsystem reset.
  function fsub(input integer n);
    fsub = n < 5 && n != 2;
  endfunction
  initial
  begin
    #200000;
    bad_count = bad_count + 1;
    close_out;
  end
  initial
  begin
    j = $urandom(3721);
    cyc(5);
    rst_b = 1;
    go <= 1;
    cyc(1);
    go <= 0;
    cyc(4);
    chk(rsn[0], 1);
    chk({rsn[4], sub}, 2'h3);
    chk(pll, 0);
    req = 0;
    for (i = 0; i < 15; i = i + 1)
    begin
      k = (i < 9) ? i : $urandom % 9;
      cyc(10);
      clr = 9'h1FF;
      cyc(1);
      clr = 0;
      chk(rsn, 0);
      cbs = $urandom;
      fg = $urandom;
      gf = $urandom;
      sel = 1;
      for (j = 0; j < 5; j = j + 1)
        fabric_interface_port[j*10 +: 10] = (j == 0) ? 125 : (j == 1) ? 126 : $urandom % 300;
      cyc(4);
      sel = 0;
      chk(pll, 1);
      chk(cmax, fg ? 667 : 625);
      for (j = 0; j < 5; j = j + 1)
      begin
        f = fabric_interface_port[j*10 +: 10];
        chk({dll[j], ret[j]}, {f > 125, f < 125});
      end
      if (k == 1 || k == 4)
      begin
        kind <= k == 1;
        go <= 1;
        cyc(1);
        go <= 0;
      end
      else
        req[k] = 1;
      cyc(4);
      chk(rsn[k], 1);
      chk({sub, axi, pll}, {fsub(k), fsub(k), !fsub(k)});
      if (k < 5)
        chk(core, 1);
      chk(cbr, k == 0 && cbs);
      if (k == 6)
        chk(gpr, gf);
      req = 0;
      cyc(8);
      chk(rsn[k], 1);
      if (fsub(k))
      begin
        chk(per, 4'hF);
        rel = $urandom;
        cyc(3);
        chk(per, {~rel});
        rel = 0;
      end
      $display("test %0d cause %0d done", i, k);
    end
    close_out;
  end
endmodule
